// [design/sso_status_out.sv]
// Servo amplifier status output logic with APB configuration registers.
`timescale 1ns/100ps
`default_nettype none
module sso_status_out
   import sso_pkg::*;
#(
   parameter int unsigned SPD_W   = 16,
   parameter int unsigned DROOP_W = 24,
   parameter int unsigned TRQ_W   = 16,
   parameter int unsigned ON_CYC  = ON_DELAY_CYC
)
(
   // Clock, reset and enable.
   input  wire logic               core_clk,
   input  wire logic               sys_rst,
   input  wire logic               clkEn,
   // APB slave.
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   // Drive state.
   input  wire sso_drv_s           drv,
   input  wire sso_mode_e          ctrlMode,
   input  wire logic               servo_on_in,
   input  wire logic               forward_start_in,
   input  wire logic               reverse_start_in,
   input  wire logic [SPD_W-1:0]   motorSpeed,
   input  wire logic [SPD_W-1:0]   setSpeed,
   input  wire logic [DROOP_W-1:0] droopCount,
   input  wire logic [TRQ_W-1:0]   motorTorque,
   input  wire logic [TRQ_W-1:0]   analog_torque_limit_in,
   // Status outputs.
   output logic                    fault_free_out,
   output logic                    readyOut,
   output logic                    in_position_out,
   output logic                    speed_reached_out,
   output logic                    speed_limiting_out,
   output logic                    torque_limiting_out,
   output logic                    zero_speed_out,
   output logic                    brake_interlock_out,
   output logic                    warning_out,
   output logic                    battery_warning_out,
   output logic                    gain_switch_active_out,
   output logic                    position_unknown_out,
   output logic                    ride_through_active_out,
   output logic                    parameter_error_alarm,
   output logic [CTRL_PIN_W-1:0]   sharedPin
);
   if (SPD_W < 8 || SPD_W > 16 || DROOP_W > 32 || TRQ_W > 16 || ON_CYC < 2)
   begin
      $error("sso_status_out: unsupported parameter values");
   end

   localparam int CNT_W = $clog2(ON_CYC + 1);

   // Configuration registers.
   logic [31:0]        ctrl;
   logic [31:0]        next_ctrl;
   logic [DROOP_W-1:0] inposRange;
   logic [DROOP_W-1:0] next_inposRange;
   logic [15:0]        zeroThr;
   logic [15:0]        next_zeroThr;
   logic [15:0]        brakeDelay;
   logic [15:0]        next_brakeDelay;
   logic [TRQ_W-1:0]   fwdLimit;
   logic [TRQ_W-1:0]   next_fwdLimit;
   logic [TRQ_W-1:0]   revLimit;
   logic [TRQ_W-1:0]   next_revLimit;
   logic [SPD_W-1:0]   spdLimit [SPD_LIMIT_NUM];
   logic [SPD_W-1:0]   next_spdLimit [SPD_LIMIT_NUM];
   logic [31:0]        next_prdata;

   wire logic apbWr = psel && penable && pwrite;
   wire logic apbRd = psel && !penable && !pwrite;
   logic      hit;

   always_comb
   begin
      next_ctrl       = ctrl;
      next_inposRange = inposRange;
      next_zeroThr    = zeroThr;
      next_brakeDelay = brakeDelay;
      next_fwdLimit   = fwdLimit;
      next_revLimit   = revLimit;
      next_spdLimit   = spdLimit;
      next_prdata     = prdata;
      hit             = 1'b1;
      case (paddr)
         REG_CTRL: next_prdata = ctrl;
         REG_INPR: next_prdata = 32'(inposRange);
         REG_ZSPD: next_prdata = 32'(zeroThr);
         REG_BRKD: next_prdata = 32'(brakeDelay);
         REG_FTRQ: next_prdata = 32'(fwdLimit);
         REG_RTRQ: next_prdata = 32'(revLimit);
         REG_STAT: next_prdata = {17'h00000, parameter_error_alarm, sharedPin,
                                  ride_through_active_out, position_unknown_out,
                                  gain_switch_active_out, battery_warning_out,
                                  warning_out, brake_interlock_out, zero_speed_out,
                                  torque_limiting_out, speed_limiting_out,
                                  speed_reached_out, in_position_out};
         default:
         begin
            hit = 1'b0;
            for (int i = 0; i < SPD_LIMIT_NUM; i++)
               if (paddr == REG_SLIM0 + 8'(4 * i))
               begin
                  hit         = 1'b1;
                  next_prdata = 32'(spdLimit[i]);
               end
         end
      endcase
      if (!apbRd)
         next_prdata = prdata;
      if (apbWr)
      begin
         case (paddr)
            REG_CTRL: next_ctrl       = pwdata;
            REG_INPR: next_inposRange = pwdata[DROOP_W-1:0];
            REG_ZSPD: next_zeroThr    = pwdata[15:0];
            REG_BRKD: next_brakeDelay = pwdata[15:0];
            REG_FTRQ: next_fwdLimit   = pwdata[TRQ_W-1:0];
            REG_RTRQ: next_revLimit   = pwdata[TRQ_W-1:0];
            default:
               for (int i = 0; i < SPD_LIMIT_NUM; i++)
                  if (paddr == REG_SLIM0 + 8'(4 * i))
                     next_spdLimit[i] = pwdata[SPD_W-1:0];
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         ctrl       <= CTRL_RESET;
         inposRange <= '0;
         zeroThr    <= ZSPD_RESET;
         brakeDelay <= '0;
         fwdLimit   <= '1;
         revLimit   <= '1;
         for (int i = 0; i < SPD_LIMIT_NUM; i++)
            spdLimit[i] <= '1;
         prdata     <= '0;
      end
      else if (clkEn)
      begin
         ctrl       <= next_ctrl;
         inposRange <= next_inposRange;
         zeroThr    <= next_zeroThr;
         brakeDelay <= next_brakeDelay;
         fwdLimit   <= next_fwdLimit;
         revLimit   <= next_revLimit;
         spdLimit   <= next_spdLimit;
         prdata     <= next_prdata;
      end
   end

   // One wait-free access phase; unmapped addresses answer with an error.
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !hit;

   // Power-on timer and status evaluation.
   logic [CNT_W-1:0] onCnt;
   logic [CNT_W-1:0] next_onCnt;
   logic [15:0]      brkCnt;
   logic [15:0]      next_brkCnt;
   logic             servoPrev;
   logic             next_servoPrev;
   logic [12:0]      outs;
   logic [12:0]      next_outs;
   logic [CTRL_PIN_W-1:0] next_sharedPin;
   logic             next_perr;
   logic             powerUp;
   logic [SPD_W+1:0] band;
   logic [SPD_W+1:0] spdDiff;
   logic             anyLimit;
   logic             rdyN;
   logic             zeroN;
   logic             inposN;
   logic             brkN;
   logic             fltN;
   sso_sel_e         sel;
   logic             normal;

   always_comb
   begin
      next_onCnt   = onCnt;
      next_servoPrev = servo_on_in;
      if (onCnt != CNT_W'(ON_CYC))
         next_onCnt = onCnt + 1'b1;
      powerUp = (onCnt == CNT_W'(ON_CYC));
      next_brkCnt = brkCnt;
      if (!servo_on_in || drv.alarm)
         next_brkCnt = '0;
      else if (brkCnt != brakeDelay)
         next_brkCnt = brkCnt + 1'b1;
      fltN = powerUp && !drv.alarm && !(ctrl[CTRL_WRN_FLT] && drv.warning);
      rdyN = servo_on_in && drv.ampReady;
      inposN = servo_on_in && ((droopCount <= inposRange) || (servo_on_in && !servoPrev));
      zeroN = (16'(motorSpeed) <= zeroThr);
      brkN = servo_on_in && !drv.alarm && (brkCnt == brakeDelay);
      band = (SPD_W+2)'(setSpeed / SPD_W'(REACH_PCT_DIV)) + (SPD_W+2)'(REACH_PAD_RPM);
      spdDiff = (motorSpeed > setSpeed) ? (SPD_W+2)'(motorSpeed - setSpeed)
                                        : (SPD_W+2)'(setSpeed - motorSpeed);
      anyLimit = 1'b0;
      for (int i = 0; i < SPD_LIMIT_NUM; i++)
         if (motorSpeed >= spdLimit[i])
            anyLimit = 1'b1;
      next_outs = '0;
      next_outs[0] = fltN;
      next_outs[1] = rdyN;
      next_outs[2] = inposN && (ctrlMode == MODE_POS);
      next_outs[3] = servo_on_in && (forward_start_in || reverse_start_in) &&
                     (ctrlMode == MODE_SPD) &&
                     ((setSpeed <= SPD_W'(REACH_LOW_RPM)) || (spdDiff <= band));
      next_outs[4] = servo_on_in && anyLimit && (ctrlMode == MODE_TRQ);
      next_outs[5] = (motorTorque >= fwdLimit) || (motorTorque >= revLimit) ||
                     (motorTorque >= analog_torque_limit_in);
      next_outs[6] = zeroN;
      next_outs[7] = brkN;
      next_outs[8] = drv.warning;
      next_outs[9] = drv.batCable || drv.batLow;
      next_outs[10] = drv.gainSw;
      next_outs[11] = !drv.absKnown && (ctrlMode == MODE_POS);
      next_outs[12] = ctrl[CTRL_RIDE_EN] && drv.rideThru;
      // parameter error on conflicting pin assignment
      next_perr = 1'b0;
      normal = 1'b0;
      for (int p = 0; p < CTRL_PIN_W; p++)
      begin
         sel = sso_sel_e'(ctrl[CTRL_PIN0 + 3*p +: 3]);
         case (sel)
            SEL_RDY: normal = rdyN;
            SEL_ZERO: normal = zeroN;
            SEL_INPOS: normal = inposN;
            SEL_BRK: normal = brkN;
            SEL_FLT: normal = fltN;
            default: normal = 1'b0;
         endcase
         if (ctrl[CTRL_ACD_EN] && (sel == SEL_BRK || sel == SEL_FLT))
            next_perr = 1'b1;
         next_sharedPin[p] = (ctrl[CTRL_ACD_EN] && drv.alarm) ? drv.alarmCode[p] : normal;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         onCnt                 <= '0;
         brkCnt                <= '0;
         servoPrev             <= 1'b0;
         outs                  <= '0;
         sharedPin             <= '0;
         parameter_error_alarm <= 1'b0;
      end
      else if (clkEn)
      begin
         onCnt                 <= next_onCnt;
         brkCnt                <= next_brkCnt;
         servoPrev             <= next_servoPrev;
         outs                  <= next_outs;
         sharedPin             <= next_sharedPin;
         parameter_error_alarm <= next_perr;
      end
   end

   assign fault_free_out          = outs[0];
   assign readyOut                = outs[1];
   assign in_position_out         = outs[2];
   assign speed_reached_out       = outs[3];
   assign speed_limiting_out      = outs[4];
   assign torque_limiting_out     = outs[5];
   assign zero_speed_out          = outs[6];
   assign brake_interlock_out     = outs[7];
   assign warning_out             = outs[8];
   assign battery_warning_out     = outs[9];
   assign gain_switch_active_out  = outs[10];
   assign position_unknown_out    = outs[11];
   assign ride_through_active_out = outs[12];

   // Assertions.
   chk_alarm_fault: assert property (@(posedge core_clk) disable iff (sys_rst)
      clkEn && drv.alarm |=> !fault_free_out)
      else $error("fault-free high after alarm");
   chk_warn_fault: assert property (@(posedge core_clk) disable iff (sys_rst)
      clkEn && ctrl[CTRL_WRN_FLT] && drv.warning |=> !fault_free_out)
      else $error("fault-free high after warning");
   chk_ready_on: assert property (@(posedge core_clk) disable iff (sys_rst)
      clkEn && servo_on_in && drv.ampReady |=> readyOut)
      else $error("ready not asserted");
   chk_reach_off: assert property (@(posedge core_clk) disable iff (sys_rst)
      clkEn && !servo_on_in |=> !speed_reached_out)
      else $error("speed reached during servo off");
   chk_limit_off: assert property (@(posedge core_clk) disable iff (sys_rst)
      clkEn && !servo_on_in |=> !speed_limiting_out)
      else $error("speed limiting during servo off");
   chk_brake_off: assert property (@(posedge core_clk) disable iff (sys_rst)
      clkEn && (drv.alarm || !servo_on_in) |=> !brake_interlock_out)
      else $error("brake interlock high on alarm");
   chk_warn_follow: assert property (@(posedge core_clk) disable iff (sys_rst)
      clkEn |=> warning_out == $past(drv.warning))
      else $error("warning output mismatch");
   chk_abs_mode: assert property (@(posedge core_clk) disable iff (sys_rst)
      clkEn && ctrlMode != MODE_POS |=> !position_unknown_out)
      else $error("position unknown outside position mode");
   chk_code_pins: assert property (@(posedge core_clk) disable iff (sys_rst)
      clkEn && ctrl[CTRL_ACD_EN] && drv.alarm |=> sharedPin == $past(drv.alarmCode))
      else $error("alarm code not on shared pins");
   chk_ride_off: assert property (@(posedge core_clk) disable iff (sys_rst)
      clkEn && !ctrl[CTRL_RIDE_EN] |=> !ride_through_active_out)
      else $error("ride-through output while disabled");
   chk_zero_speed: assert property (@(posedge core_clk) disable iff (sys_rst)
      clkEn |=> zero_speed_out == (16'($past(motorSpeed)) <= $past(zeroThr)))
      else $error("zero speed output mismatch");
   chk_gain_follow: assert property (@(posedge core_clk) disable iff (sys_rst)
      clkEn |=> gain_switch_active_out == $past(drv.gainSw))
      else $error("gain switch output mismatch");
   chk_bat_follow: assert property (@(posedge core_clk) disable iff (sys_rst)
      clkEn |=> battery_warning_out == $past(drv.batCable || drv.batLow))
      else $error("battery warning output mismatch");

   cov_fault_up: cover property (@(posedge core_clk) $rose(fault_free_out));
   cov_code_out: cover property (@(posedge core_clk) ctrl[CTRL_ACD_EN] && drv.alarm);
   cov_perr: cover property (@(posedge core_clk) parameter_error_alarm);
   cov_reach: cover property (@(posedge core_clk) speed_reached_out);
   cov_inpos_son: cover property (@(posedge core_clk) $rose(in_position_out));
endmodule
`default_nettype wire

// [design/sso_pkg.sv]
// Package with register map, field layout and timing constants of the status output block.
package sso_pkg;
   localparam int unsigned CLK_HZ          = 125_000_000;
   localparam int unsigned ON_DELAY_MIN_MS = 2500;
   localparam int unsigned ON_DELAY_MAX_MS = 3500;
   // Midpoint of the allowed window, so both bounds hold with margin.
   localparam int unsigned ON_DELAY_MS     = 3000;
   localparam int unsigned ON_DELAY_CYC    = (CLK_HZ / 1000) * ON_DELAY_MS;
   localparam int unsigned REACH_PAD_RPM   = 20;
   localparam int unsigned REACH_PCT_DIV   = 20;
   localparam int unsigned REACH_LOW_RPM   = 20;
   localparam int unsigned ZERO_DEF_RPM    = 50;
   localparam int unsigned SPD_LIMIT_NUM   = 7;

   // Register byte addresses.
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_INPR   = 8'h04;
   localparam logic [7:0] REG_ZSPD   = 8'h08;
   localparam logic [7:0] REG_BRKD   = 8'h0C;
   localparam logic [7:0] REG_FTRQ   = 8'h10;
   localparam logic [7:0] REG_RTRQ   = 8'h14;
   localparam logic [7:0] REG_STAT   = 8'h18;
   localparam logic [7:0] REG_SLIM0  = 8'h20;

   // Control register fields.
   localparam int unsigned CTRL_WRN_FLT = 0;
   localparam int unsigned CTRL_ACD_EN  = 1;
   localparam int unsigned CTRL_RIDE_EN = 2;
   localparam int unsigned CTRL_PIN0    = 4;
   localparam int unsigned CTRL_PIN_W   = 3;

   localparam logic [15:0] ZSPD_RESET = 16'(ZERO_DEF_RPM);
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // Signal selection for each shared pin: what is assigned there.
   typedef enum logic [2:0] {
      SEL_RDY = 3'h0, SEL_ZERO = 3'h1, SEL_INPOS = 3'h2,
      SEL_BRK = 3'h3, SEL_FLT = 3'h4
   } sso_sel_e;

   typedef enum logic [1:0] {
      MODE_POS = 2'h0, MODE_SPD = 2'h1, MODE_TRQ = 2'h3
   } sso_mode_e;

   typedef struct packed {
      logic alarm;
      logic warning;
      logic batCable;
      logic batLow;
      logic ampReady;
      logic gainSw;
      logic absKnown;
      logic rideThru;
      logic [2:0] alarmCode;
   } sso_drv_s;
endpackage

// [verification/sso_ctrl_model.sv]
// Controller input stage that latches the shared status pins of the amplifier.
`timescale 1ns/100ps
`default_nettype none
module sso_ctrl_model
(
   // Clock and reset.
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   // Shared status pins from the amplifier.
   input  wire logic [2:0] pinIn,
   // Latched view for the controller.
   output logic [2:0]      pinSeen
);
   // Sampled every cycle, so a pin that holds one cycle is never missed.
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         pinSeen <= '0;
      else
         pinSeen <= pinIn;
   end
endmodule
`default_nettype wire

// [verification/sso_status_out_tb.sv]
// Self-checking testbench of the status output block.
`timescale 1ns/100ps
`default_nettype none
module sso_status_out_tb;
   import sso_pkg::*;
   localparam logic [31:0] PINS = (32'h1 << 7) | (32'h2 << 10) | (32'h1 << CTRL_ACD_EN);
   logic core_clk, sys_rst, clkEn, psel, penable, pwrite, pready, pslverr, err, seen;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   sso_drv_s    drv;
   sso_mode_e   ctrlMode;
   logic servo_on_in, forward_start_in, reverse_start_in;
   logic [15:0] motorSpeed, setSpeed, motorTorque, analog_torque_limit_in;
   logic [23:0] droopCount;
   logic fault_free_out, readyOut, in_position_out, speed_reached_out, speed_limiting_out;
   logic torque_limiting_out, zero_speed_out, brake_interlock_out, warning_out;
   logic battery_warning_out, gain_switch_active_out, position_unknown_out;
   logic ride_through_active_out, parameter_error_alarm;
   logic [2:0]  sharedPin, pinSeen;
   int          failCount, checkCount;

   sso_status_out #(.ON_CYC(50)) u_sso_status_out (.core_clk, .sys_rst, .clkEn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .drv, .ctrlMode,
      .servo_on_in, .forward_start_in, .reverse_start_in, .motorSpeed, .setSpeed,
      .droopCount, .motorTorque, .analog_torque_limit_in, .fault_free_out, .readyOut,
      .in_position_out, .speed_reached_out, .speed_limiting_out, .torque_limiting_out,
      .zero_speed_out, .brake_interlock_out, .warning_out, .battery_warning_out,
      .gain_switch_active_out, .position_unknown_out, .ride_through_active_out,
      .parameter_error_alarm, .sharedPin);
   sso_ctrl_model u_sso_ctrl_model (.core_clk, .sys_rst, .pinIn(sharedPin), .pinSeen);

   always #4 core_clk = ~core_clk;

   task automatic check(input string name, input logic [31:0] s, input logic [31:0] e);
      checkCount++;
      if (s !== e)
      begin
         failCount++;
         $display("MISMATCH %s expected %h seen %h", name, e, s);
      end
   endtask

   // The master holds the request until pready is sampled high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge core_clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic settle();
      repeat (3) @(posedge core_clk);
      #1;
   endtask

   task automatic finishTest();
      if (failCount == 0 && checkCount > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge core_clk);
      failCount++;
      finishTest();
   end

   initial
   begin
      core_clk = 0; sys_rst = 1; clkEn = 1; psel = 0; penable = 0; pwrite = 0;
      paddr = '0; pwdata = '0; drv = '0; ctrlMode = MODE_POS; servo_on_in = 0;
      forward_start_in = 0; reverse_start_in = 0; motorSpeed = '0; setSpeed = '0;
      droopCount = '0; motorTorque = '0; analog_torque_limit_in = 16'hFFFF;
      failCount = 0; checkCount = 0;
      repeat (5) @(posedge core_clk);
      #1;
      check("ff_rst", fault_free_out, 0);
      check("zero_rst", zero_speed_out, 0);
      @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (20) @(posedge core_clk);
      #1;
      check("ff_early", fault_free_out, 0);
      apb(0, REG_ZSPD, 0);
      check("zspd_reset", rd[15:0], ZSPD_RESET);
      apb(0, 8'hFC, 0);
      check("unmapped", err, 1);
      repeat (40) @(posedge core_clk);
      #1;
      check("ff_late", fault_free_out, 1);
      check("warn_idle", warning_out, 0);
      // A low enable freezes every registered output, so a new warning must not pass.
      @(posedge core_clk);
      clkEn <= 1'b0;
      drv.warning <= 1'b1;
      settle();
      check("warn_frozen", warning_out, 0);
      @(posedge core_clk);
      clkEn <= 1'b1;
      settle();
      check("warn_thaw", warning_out, 1);
      // Zero speed threshold boundary.
      @(posedge core_clk);
      drv.warning <= 1'b0;
      motorSpeed <= 16'h0032;
      settle();
      check("zero_50", zero_speed_out, 1);
      @(posedge core_clk);
      motorSpeed <= 16'h0033;
      settle();
      check("zero_51", zero_speed_out, 0);
      // Alarm, then warning with both fault settings.
      @(posedge core_clk);
      drv.alarm <= 1'b1;
      settle();
      check("ff_alarm", fault_free_out, 0);
      @(posedge core_clk);
      drv.alarm <= 1'b0;
      drv.warning <= 1'b1;
      settle();
      check("ff_warn", fault_free_out, 1);
      check("warn_on", warning_out, 1);
      apb(1, REG_CTRL, 32'h1 << CTRL_WRN_FLT);
      settle();
      check("ff_warn_alt", fault_free_out, 0);
      @(posedge core_clk);
      drv.warning <= 1'b0;
      settle();
      check("ff_clear", fault_free_out, 1);
      apb(1, REG_CTRL, 0);
      for (int i = 1; i < 4; i++)
      begin
         @(posedge core_clk);
         {drv.batCable, drv.batLow} <= i[1:0];
         settle();
         check("bat_warn", battery_warning_out, 1);
      end
      @(posedge core_clk);
      {drv.batCable, drv.batLow} <= 2'h0;
      settle();
      check("bat_idle", battery_warning_out, 0);
      // Servo-on: ready, brake, in-position.
      apb(1, REG_BRKD, 32'h4);
      apb(1, REG_INPR, 32'h64);
      @(posedge core_clk);
      servo_on_in <= 1'b1;
      drv.ampReady <= 1'b1;
      droopCount <= 24'h64;
      repeat (12) @(posedge core_clk);
      #1;
      check("ready", readyOut, 1);
      check("brake_on", brake_interlock_out, 1);
      check("inpos_100", in_position_out, 1);
      @(posedge core_clk);
      droopCount <= 24'h65;
      drv.alarm <= 1'b1;
      settle();
      check("inpos_101", in_position_out, 0);
      check("brake_alarm", brake_interlock_out, 0);
      @(posedge core_clk);
      drv.alarm <= 1'b0;
      servo_on_in <= 1'b0;
      settle();
      check("brake_off", brake_interlock_out, 0);
      @(posedge core_clk);
      servo_on_in <= 1'b1;
      seen = 0;
      repeat (4)
      begin
         @(posedge core_clk);
         #1;
         seen |= in_position_out;
      end
      check("inpos_son", seen, 1);
      // Alarm code on the shared pins: ready, zero speed, in-position.
      @(posedge core_clk);
      motorSpeed <= '0;
      apb(1, REG_CTRL, PINS);
      settle();
      check("pins_norm", sharedPin, 3'h3);
      check("perr_ok", parameter_error_alarm, 0);
      @(posedge core_clk);
      drv.alarm <= 1'b1;
      drv.alarmCode <= 3'h5;
      settle();
      check("pins_code", sharedPin, 3'h5);
      check("pins_ctrl", pinSeen, 3'h5);
      // Status word: zero speed, position unknown and code 5 on the shared pins.
      apb(0, REG_STAT, 0);
      check("stat_word", rd, 32'h0000_2A10);
      @(posedge core_clk);
      drv.alarm <= 1'b0;
      apb(1, REG_CTRL, PINS | (32'(SEL_BRK) << CTRL_PIN0));
      settle();
      check("perr_brk", parameter_error_alarm, 1);
      apb(1, REG_CTRL, 0);
      // Gain switch, absolute position, ride-through.
      @(posedge core_clk);
      drv.gainSw <= 1'b1;
      drv.rideThru <= 1'b1;
      settle();
      check("gain_sw", gain_switch_active_out, 1);
      check("pos_unk", position_unknown_out, 1);
      check("ride_dis", ride_through_active_out, 0);
      apb(1, REG_CTRL, 32'h1 << CTRL_RIDE_EN);
      @(posedge core_clk);
      drv.gainSw <= 1'b0;
      ctrlMode <= MODE_SPD;
      settle();
      check("ride_en", ride_through_active_out, 1);
      check("gain_off", gain_switch_active_out, 0);
      check("pos_unk_spd", position_unknown_out, 0);
      // Speed band: 1000 plus or minus 70.
      @(posedge core_clk);
      forward_start_in <= 1'b1;
      setSpeed <= 16'h03E8;
      for (int i = 0; i < 4; i++)
      begin
         @(posedge core_clk);
         motorSpeed <= (i < 2) ? 16'(1070 + i) : 16'(930 - (i - 2));
         settle();
         check("reach_band", speed_reached_out, i[0] ? 0 : 1);
      end
      @(posedge core_clk);
      setSpeed <= 16'h0014;
      settle();
      check("reach_low", speed_reached_out, 1);
      @(posedge core_clk);
      setSpeed <= 16'h03E8;
      motorSpeed <= 16'h03E8;
      forward_start_in <= 1'b0;
      settle();
      check("reach_nostart", speed_reached_out, 0);
      // Torque limits.
      apb(1, REG_FTRQ, 32'h64);
      apb(1, REG_RTRQ, 32'h64);
      @(posedge core_clk);
      motorTorque <= 16'h0063;
      settle();
      check("torq_99", torque_limiting_out, 0);
      @(posedge core_clk);
      motorTorque <= 16'h0064;
      settle();
      check("torq_100", torque_limiting_out, 1);
      apb(1, REG_FTRQ, 32'hFFFF_FFFF);
      apb(1, REG_RTRQ, 32'hFFFF_FFFF);
      @(posedge core_clk);
      analog_torque_limit_in <= 16'h0032;
      motorTorque <= 16'h003C;
      settle();
      check("torq_analog", torque_limiting_out, 1);
      // Each of the seven speed limits in torque mode.
      @(posedge core_clk);
      ctrlMode <= MODE_TRQ;
      motorSpeed <= 16'h01F4;
      settle();
      check("slim_none", speed_limiting_out, 0);
      for (int i = 0; i < SPD_LIMIT_NUM; i++)
      begin
         apb(1, REG_SLIM0 + 8'(4 * i), 32'h1F4);
         settle();
         check("slim_hit", speed_limiting_out, 1);
         if (i < SPD_LIMIT_NUM - 1)
            apb(1, REG_SLIM0 + 8'(4 * i), 32'hFFFF_FFFF);
      end
      @(posedge core_clk);
      servo_on_in <= 1'b0;
      settle();
      check("slim_soff", speed_limiting_out, 0);
      finishTest();
   end
endmodule
`default_nettype wire
